// >>> core/scsr_regs.sv
// Purpose: Two-wire bus slave with charger event flags, soft reset, ship timer select and bus config
// Assumes: SCL and SDA are slow against clk_sys_i; SDA is open drain
// Notes:   Whole design sits on clk_sys_i; bus pins are oversampled
`timescale 1ns/100ps
module scsr_regs
    import scsr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR       = SCSR_DEV_ADDR_DEFAULT,
    parameter int         SHIP_LONG_CYC  = SCSR_SHIP_LONG_CYC,
    parameter int         SHIP_SHORT_CYC = SCSR_SHIP_SHORT_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic [7:0] event_ok_i,
    input  wire logic       ship_exit_req_i,
    output logic            ship_exit_o,
    output logic [7:0]      event_pending_o,
    output logic            fast_mode_o,
    output scsr_ctrl_s      ctrl_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] scl_sync_r, sda_sync_r, ship_sync_r;
    logic [7:0] ok_meta_r, ok_sync_r, ok_prev_r;
    logic       scl_prev_r, sda_prev_r;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            scl_sync_r  <= 2'h3;
            sda_sync_r  <= 2'h3;
            ship_sync_r <= 2'h0;
            ok_meta_r   <= event_ok_i; // Follow pins in reset, so no false event after it
            ok_sync_r   <= ok_meta_r;
            scl_prev_r  <= 1'b1;
            sda_prev_r  <= 1'b1;
        end else begin
            scl_sync_r  <= {scl_sync_r[0], scl_i};
            sda_sync_r  <= {sda_sync_r[0], sda_i};
            ship_sync_r <= {ship_sync_r[0], ship_exit_req_i};
            ok_meta_r   <= event_ok_i;
            ok_sync_r   <= ok_meta_r;
            scl_prev_r  <= scl_sync_r[1];
            sda_prev_r  <= sda_sync_r[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_s     = scl_sync_r[1];
    assign sda_s     = sda_sync_r[1];
    assign scl_rise  = scl_s & ~scl_prev_r;
    assign scl_fall  = ~scl_s & scl_prev_r;
    assign bus_start = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
    assign bus_stop  = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] flags_r, mask_r, config_r, key_r, ship_r, rd_data;
    logic       wr_en_r, rd_clr_r;
    logic [7:0] wr_addr_r, wr_data_r;
    logic       soft_rst;

    assign soft_rst = wr_en_r && wr_addr_r == SCSR_ADDR_RESET_KEY && wr_data_r == SCSR_SOFT_RESET_KEY;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || soft_rst) begin
            mask_r   <= SCSR_RST_EVENT_MASK;
            config_r <= SCSR_RST_BUS_CONFIG;
            key_r    <= SCSR_RST_RESET_KEY;
            ship_r   <= SCSR_RST_SHIP_CTRL;
        end else if (wr_en_r) begin
            case (wr_addr_r)
                SCSR_ADDR_EVENT_MASK: mask_r   <= wr_data_r;
                SCSR_ADDR_BUS_CONFIG: config_r <= wr_data_r;
                SCSR_ADDR_RESET_KEY:  key_r    <= wr_data_r;
                SCSR_ADDR_SHIP_CTRL:  ship_r   <= wr_data_r;
                default: ;
            endcase
        end
    end

    // Change since last read; a change in the read cycle survives the clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || soft_rst) begin
            flags_r   <= SCSR_RST_EVENT_FLAGS;
            ok_prev_r <= ok_sync_r;
        end else begin
            flags_r   <= ((rd_clr_r ? 8'h00 : flags_r) | (ok_sync_r ^ ok_prev_r)) & SCSR_EVENT_IMPL_MASK;
            ok_prev_r <= ok_sync_r;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            event_pending_o <= 8'h00;
        end else begin
            event_pending_o <= flags_r & ~mask_r;
        end
    end

    always_comb begin
        case (wr_addr_r)
            SCSR_ADDR_EVENT_FLAGS: rd_data = flags_r;
            SCSR_ADDR_EVENT_MASK:  rd_data = mask_r;
            SCSR_ADDR_EVENT_OK:    rd_data = ok_sync_r & SCSR_EVENT_IMPL_MASK;
            SCSR_ADDR_BUS_CONFIG:  rd_data = config_r;
            SCSR_ADDR_RESET_KEY:   rd_data = key_r;
            SCSR_ADDR_SHIP_CTRL:   rd_data = ship_r;
            default:               rd_data = 8'h00;
        endcase
    end

    assign ctrl_o.pair_mode            = config_r[SCSR_BIT_PAIR_MODE];
    assign ctrl_o.fast_mode_persist_en = config_r[SCSR_BIT_FAST_PERSIST];
    assign ctrl_o.ship_exit_timer_sel  = ship_r[SCSR_BIT_SHIP_TSEL];

    // ****************************************
    // Ship exit timer
    // ****************************************
    localparam int SHIP_W = $clog2(SHIP_LONG_CYC + 1);
    logic [SHIP_W-1:0] ship_cnt_r, ship_limit;
    logic              ship_done_r;

    assign ship_limit = ship_r[SCSR_BIT_SHIP_TSEL] ? SHIP_W'(SHIP_SHORT_CYC) : SHIP_W'(SHIP_LONG_CYC);

    // Request must stay high for the whole selected time; one pulse per press
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !ship_sync_r[1]) begin
            ship_cnt_r  <= '0;
            ship_done_r <= 1'b0;
            ship_exit_o <= 1'b0;
        end else begin
            ship_exit_o <= 1'b0;
            if (!ship_done_r) begin
                ship_cnt_r <= ship_cnt_r + 1'b1;
                if (ship_cnt_r + 1'b1 >= ship_limit) begin
                    ship_done_r <= 1'b1;
                    ship_exit_o <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Two-wire bus engine
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} scsr_state_e;
    scsr_state_e state_r;
    scsr_kind_e  kind_r;
    logic [7:0]  shift_r;
    logic [3:0]  bit_cnt_r;
    logic        wr_step_r, go_tx_r, drive_low_r, fast_code_r;

    assign sda_o       = 1'b0;
    assign sda_oe_n_o  = ~drive_low_r;
    assign fast_mode_o = fast_code_r | config_r[SCSR_BIT_FAST_PERSIST];

    // Entry code arms fast mode; STOP drops it only without persistence
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fast_code_r <= 1'b0;
        end else if (bus_stop && !config_r[SCSR_BIT_FAST_PERSIST]) begin
            fast_code_r <= 1'b0;
        end else if (state_r == ST_RX && kind_r == SCSR_KIND_ADDR && scl_fall && bit_cnt_r == 4'h8
                     && shift_r[7:3] == SCSR_FAST_ENTRY_CODE) begin
            fast_code_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            kind_r      <= SCSR_KIND_ADDR;
            shift_r     <= 8'h00;
            bit_cnt_r   <= 4'h0;
            wr_step_r   <= 1'b0;
            go_tx_r     <= 1'b0;
            drive_low_r <= 1'b0;
            wr_en_r     <= 1'b0;
            rd_clr_r    <= 1'b0;
            wr_addr_r   <= 8'h00;
            wr_data_r   <= 8'h00;
        end else begin
            wr_en_r  <= 1'b0;
            rd_clr_r <= 1'b0;
            if (bus_start) begin
                state_r     <= ST_RX;
                kind_r      <= SCSR_KIND_ADDR;
                bit_cnt_r   <= 4'h0;
                drive_low_r <= 1'b0;
            end else if (bus_stop) begin
                state_r     <= ST_IDLE;
                drive_low_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: ;
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r   <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            state_r     <= ST_ACK;
                            drive_low_r <= 1'b1;
                            go_tx_r     <= 1'b0;
                            wr_step_r   <= 1'b0;
                            case (kind_r)
                                SCSR_KIND_ADDR: begin
                                    // Entry code is never acknowledged
                                    if (shift_r[7:1] != DEV_ADDR) begin
                                        state_r     <= ST_IDLE;
                                        drive_low_r <= 1'b0;
                                    end
                                    go_tx_r <= shift_r[0];
                                    kind_r  <= SCSR_KIND_REG;
                                end
                                SCSR_KIND_REG: begin
                                    wr_addr_r <= shift_r;
                                    kind_r    <= SCSR_KIND_DATA;
                                end
                                SCSR_KIND_DATA: begin
                                    wr_en_r   <= 1'b1;
                                    wr_data_r <= shift_r;
                                    wr_step_r <= !config_r[SCSR_BIT_PAIR_MODE];
                                    if (config_r[SCSR_BIT_PAIR_MODE]) begin
                                        kind_r <= SCSR_KIND_REG;
                                    end
                                end
                                default: kind_r <= SCSR_KIND_ADDR;
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 4'h0;
                            if (go_tx_r) begin
                                state_r     <= ST_TX;
                                shift_r     <= rd_data;
                                drive_low_r <= ~rd_data[7];
                                rd_clr_r    <= wr_addr_r == SCSR_ADDR_EVENT_FLAGS;
                            end else begin
                                state_r     <= ST_RX;
                                drive_low_r <= 1'b0;
                                if (wr_step_r) begin
                                    wr_addr_r <= wr_addr_r + 8'h01;
                                end
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                state_r     <= ST_TXACK;
                                drive_low_r <= 1'b0;
                            end else begin
                                shift_r     <= {shift_r[6:0], 1'b0};
                                drive_low_r <= ~shift_r[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            go_tx_r   <= ~sda_s;
                            wr_addr_r <= wr_addr_r + 8'h01;
                        end else if (scl_fall) begin
                            state_r     <= go_tx_r ? ST_TX : ST_IDLE;
                            bit_cnt_r   <= 4'h0;
                            shift_r     <= rd_data;
                            drive_low_r <= go_tx_r & ~rd_data[7];
                            rd_clr_r    <= go_tx_r && wr_addr_r == SCSR_ADDR_EVENT_FLAGS;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // scsr_regs

// >>> core/scsr_pkg.sv
// Purpose: Shared constants and types of the serial configuration and soft reset register bank
// Assumes: 25 MHz system clock
// Notes:   Offsets are register addresses on the two-wire bus
package scsr_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] SCSR_ADDR_EVENT_FLAGS = 8'h10;
    localparam logic [7:0] SCSR_ADDR_EVENT_MASK  = 8'h11;
    localparam logic [7:0] SCSR_ADDR_EVENT_OK    = 8'h12;
    localparam logic [7:0] SCSR_ADDR_BUS_CONFIG  = 8'h40;
    localparam logic [7:0] SCSR_ADDR_RESET_KEY   = 8'h50;
    localparam logic [7:0] SCSR_ADDR_SHIP_CTRL   = 8'h51;

    // ****************************************
    // Reset values and keys
    // ****************************************
    localparam logic [7:0] SCSR_RST_EVENT_FLAGS  = 8'h00;
    localparam logic [7:0] SCSR_RST_EVENT_MASK   = 8'hff;
    localparam logic [7:0] SCSR_RST_BUS_CONFIG   = 8'h00;
    localparam logic [7:0] SCSR_RST_RESET_KEY    = 8'h00;
    localparam logic [7:0] SCSR_RST_SHIP_CTRL    = 8'h00;
    localparam logic [7:0] SCSR_SOFT_RESET_KEY   = 8'ha5;
    localparam logic [7:0] SCSR_EVENT_IMPL_MASK  = 8'hfb;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SCSR_BIT_PAIR_MODE   = 4;
    localparam int SCSR_BIT_FAST_PERSIST = 0;
    localparam int SCSR_BIT_SHIP_TSEL   = 0;

    // ****************************************
    // Bus codes
    // ****************************************
    localparam logic [6:0] SCSR_DEV_ADDR_DEFAULT = 7'h6b; // Arbitrary value
    localparam logic [4:0] SCSR_FAST_ENTRY_CODE  = 5'h01;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SCSR_CLK_HZ          = 25_000_000;
    localparam int SCSR_SHIP_LONG_US    = 10_000;
    localparam int SCSR_SHIP_SHORT_US10 = 1;        // 0.1 ms in units of 100 us
    localparam int SCSR_SHIP_LONG_CYC   = SCSR_CLK_HZ / 1_000_000 * SCSR_SHIP_LONG_US;
    localparam int SCSR_SHIP_SHORT_CYC  = SCSR_CLK_HZ / 10_000 * SCSR_SHIP_SHORT_US10;

    typedef struct packed {
        logic pair_mode;
        logic fast_mode_persist_en;
        logic ship_exit_timer_sel;
    } scsr_ctrl_s;

    typedef enum logic [1:0] {
        SCSR_KIND_ADDR,
        SCSR_KIND_REG,
        SCSR_KIND_DATA
    } scsr_kind_e;

endpackage

// >>> testbench/scsr_regs_sva.sv
// Purpose: Port checker for the register bank
// Assumes: Bus pins are oversampled with a few cycles of latency
// Notes:   Bound to every register bank instance
`timescale 1ns/100ps
module scsr_regs_sva
    import scsr_pkg::*;
#(
    parameter int SHIP_LONG_CYC  = SCSR_SHIP_LONG_CYC,
    parameter int SHIP_SHORT_CYC = SCSR_SHIP_SHORT_CYC
) (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe_n_o,
    input wire logic       ship_exit_req_i,
    input wire logic       ship_exit_o,
    input wire logic [7:0] event_pending_o,
    input wire logic       fast_mode_o,
    input wire scsr_ctrl_s ctrl_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    int   hold_r;
    int   lim;
    logic keep;
    assign keep = ctrl_o.fast_mode_persist_en;
    assign lim  = ctrl_o.ship_exit_timer_sel ? SHIP_SHORT_CYC : SHIP_LONG_CYC;
    // Raw request length; pulse lags it by the synchroniser
    always_ff @(posedge clk_sys_i) begin
        hold_r <= (rst_i || !ship_exit_req_i) ? 0 : hold_r + 1;
    end
    AST_FAST_FORCED: assert property (keep |-> fast_mode_o)
        else $error("fast mode off while persist bit set");
    AST_FAST_KEPT: assert property ($fell(fast_mode_o) |-> $past(keep) || (scl_i && sda_i))
        else $error("fast mode dropped outside bus idle");
    AST_FAST_STOP: assert property (fast_mode_o && !keep && scl_i && $rose(sda_i) |-> ##[1:8] !fast_mode_o)
        else $error("fast mode kept after stop");
    AST_SHIP_TIME: assert property (ship_exit_o |-> hold_r >= lim && hold_r <= lim + 6)
        else $error("ship exit pulse at wrong time");
    AST_SHIP_ONCE: assert property (ship_exit_o |=> !ship_exit_o [*8])
        else $error("ship exit pulse repeated");
    AST_RSVD_FLAG: assert property (event_pending_o[2] == 1'b0)
        else $error("reserved event flag set");
    AST_ACK_SCL_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data pin changed while clock high");
    AST_CFG_IN_ACK: assert property ($changed(ctrl_o) |-> !sda_oe_n_o)
        else $error("control changed outside an acknowledged write");
endmodule // scsr_regs_sva

bind scsr_regs scsr_regs_sva #(
    .SHIP_LONG_CYC (SHIP_LONG_CYC),
    .SHIP_SHORT_CYC(SHIP_SHORT_CYC)
) scsr_regs_sva_inst (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .scl_i          (scl_i),
    .sda_i          (sda_i),
    .sda_oe_n_o     (sda_oe_n_o),
    .ship_exit_req_i(ship_exit_req_i),
    .ship_exit_o    (ship_exit_o),
    .event_pending_o(event_pending_o),
    .fast_mode_o    (fast_mode_o),
    .ctrl_o         (ctrl_o)
);

// >>> testbench/scsr_host.sv
// Purpose: Two-wire bus host model
// Assumes: Clock period of eight system cycles
// Notes:   Clock stands still high between frames
`timescale 1ns/100ps
module scsr_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic quarter();
        repeat (2) @(posedge clk_i);
    endtask
    // Works as a repeated start too
    task automatic start();
        sda_low_o <= 1'b0;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_low_o <= 1'b1;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask
    task automatic xfer_bit(input logic b, output logic r);
        sda_low_o <= ~b;
        quarter();
        scl_o <= 1'b1;
        quarter();
        r = sda_i;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask
    // Last bit: 1 releases for the device, 0 acks a read
    task automatic xfer_byte(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r[i]);
        xfer_bit(ab, a);
        ack = ~a;
    endtask
    task automatic stop();
        sda_low_o <= 1'b1;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_low_o <= 1'b0;
        quarter();
    endtask
endmodule // scsr_host

// >>> testbench/serial_config_and_soft_reset_regs_test.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Shortened ship timer counts
// Notes:   Host model drives the bus pins
`timescale 1ns/100ps
module serial_config_and_soft_reset_regs_test;
    import scsr_pkg::*;
    localparam int         LONG_CYC  = 50;
    localparam int         SHORT_CYC = 10;
    localparam logic [7:0] DEV_W     = {SCSR_DEV_ADDR_DEFAULT, 1'b0};
    logic       clk_sys_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       scl, sda_low, sda_oe_n, sda_o, ship_exit, fast;
    logic       ship_req  = 1'b0;
    logic [7:0] ev        = 8'hbb;
    logic [7:0] pend;
    scsr_ctrl_s ctrl;
    int         error_cnt   = 0;
    int         comparisons = 0;
    // Pull-up: a released line reads high
    wire sda = !(sda_low || (!sda_oe_n && !sda_o));
    always #20 clk_sys_i = ~clk_sys_i;
    scsr_regs #(
        .SHIP_LONG_CYC (LONG_CYC),
        .SHIP_SHORT_CYC(SHORT_CYC)
    ) scsr_regs_inst (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .scl_i          (scl),
        .sda_i          (sda),
        .sda_o          (sda_o),
        .sda_oe_n_o     (sda_oe_n),
        .event_ok_i     (ev),
        .ship_exit_req_i(ship_req),
        .ship_exit_o    (ship_exit),
        .event_pending_o(pend),
        .fast_mode_o    (fast),
        .ctrl_o         (ctrl)
    );
    scsr_host scsr_host_inst (
        .clk_i    (clk_sys_i),
        .sda_i    (sda),
        .scl_o    (scl),
        .sda_low_o(sda_low)
    );
    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] d);
        logic [7:0] r;
        logic       k;
        scsr_host_inst.xfer_byte(d, 1'b1, r, k);
        check({7'h00, k}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        scsr_host_inst.start();
        send(DEV_W);
        send(a);
        send(d);
        scsr_host_inst.stop();
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       k;
        scsr_host_inst.start();
        send(DEV_W);
        send(a);
        scsr_host_inst.start();
        send(DEV_W | 8'h01);
        scsr_host_inst.xfer_byte(8'hff, 1'b1, d, k);
        scsr_host_inst.stop();
        check(d, e);
    endtask
    task automatic expect_two(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] d0, d1;
        logic       k;
        scsr_host_inst.start();
        send(DEV_W);
        send(a);
        scsr_host_inst.start();
        send(DEV_W | 8'h01);
        scsr_host_inst.xfer_byte(8'hff, 1'b0, d0, k);
        scsr_host_inst.xfer_byte(8'hff, 1'b1, d1, k);
        scsr_host_inst.stop();
        check(d0, e0);
        check(d1, e1);
    endtask
    task automatic t_ship(input int lim);
        int n;
        n = 0;
        ship_req <= 1'b1;
        while (ship_exit !== 1'b1 && n < 300) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(posedge clk_sys_i);
        ship_req <= 1'b0;
        check({7'h00, n >= lim && n <= lim + 6}, 8'h01);
    endtask
    task automatic t_bursts();
        wr(8'h11, 8'h00);
        scsr_host_inst.start();
        send(DEV_W);
        send(8'h50);
        send(8'h5a);
        send(8'h02);
        scsr_host_inst.stop();
        expect_reg(8'h50, 8'h5a);
        expect_reg(8'h51, 8'h02);
        expect_two(8'h50, 8'h5a, 8'h02);
        expect_reg(8'h11, 8'h00);
        wr(8'h40, 8'h10);
        check({7'h00, ctrl.pair_mode}, 8'h01);
        scsr_host_inst.start();
        send(DEV_W);
        send(8'h11);
        send(8'h7e);
        send(8'h51);
        send(8'h00);
        scsr_host_inst.stop();
        expect_reg(8'h11, 8'h7e);
        expect_reg(8'h51, 8'h00);
        wr(8'h40, 8'h00);
    endtask
    task automatic t_flags();
        ev <= ev ^ 8'h85;
        repeat (10) @(posedge clk_sys_i);
        check(pend, 8'h81);
        expect_reg(8'h12, 8'h3a);
        expect_reg(8'h10, 8'h81);
        expect_reg(8'h10, 8'h00);
        check(pend, 8'h00);
        ev <= ev ^ 8'h40;
        repeat (10) @(posedge clk_sys_i);
        check(pend, 8'h00);
        expect_reg(8'h10, 8'h40);
    endtask
    task automatic t_fast();
        logic [7:0] r;
        logic       k;
        scsr_host_inst.start();
        scsr_host_inst.xfer_byte({SCSR_FAST_ENTRY_CODE, 3'h0}, 1'b1, r, k);
        check({7'h00, k}, 8'h00);
        check({7'h00, fast}, 8'h01);
        scsr_host_inst.stop();
        repeat (8) @(posedge clk_sys_i);
        check({7'h00, fast}, 8'h00);
        scsr_host_inst.start();
        send(DEV_W);
        send(8'h40);
        send(8'h01);
        check({7'h00, fast}, 8'h01);
        scsr_host_inst.stop();
        repeat (8) @(posedge clk_sys_i);
        check({7'h00, fast}, 8'h01);
    endtask
    task automatic t_soft_reset();
        wr(8'h51, 8'h01);
        wr(8'h50, 8'ha5);
        check({5'h00, ctrl}, 8'h00);
        expect_reg(8'h11, 8'hff);
        expect_reg(8'h40, 8'h00);
        expect_reg(8'h50, 8'h00);
        expect_reg(8'h51, 8'h00);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        expect_reg(8'h11, 8'hff);
        expect_reg(8'h40, 8'h00);
        expect_reg(8'h30, 8'h00);
        t_ship(LONG_CYC);
        wr(8'h51, 8'h01);
        t_ship(SHORT_CYC);
        t_bursts();
        t_flags();
        t_fast();
        t_soft_reset();
        close_out();
    end
endmodule // serial_config_and_soft_reset_regs_test
